//--- bench/clmx_exec_tb.sv
// ==========================================
// testbench for decode and execute
// ==========================================
module clmx_exec_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic        instr_valid = 1'b0;
    logic [31:0] instr = 32'h0, source_gpr_value = 32'h0, target_gpr_value = 32'h0;
    logic [31:0] mem_rdata, coproc_rdata, mem_addr, gpr_wdata, hi, lo, wr_d, rq_a;
    logic [3:0]  coproc_usable = 4'h5;
    logic        mem_req, coproc_req, gpr_we, exc_valid;
    logic [1:0]  coproc_num, exc_code, ex_c;
    logic [4:0]  coproc_reg, gpr_waddr, wr_a;
    int          wr_n, ex_n, rq_n, n_errors = 0, checked = 0;
    localparam logic [31:0] KEY = 32'h5a0f_c3e1;

    always #4 mclk = ~mclk;

    clmx_exec uut (.mclk(mclk), .rst(rst), .instr_valid(instr_valid), .instr(instr),
        .source_gpr_value(source_gpr_value), .target_gpr_value(target_gpr_value), .mem_rdata(mem_rdata),
        .coproc_rdata(coproc_rdata), .coproc_usable(coproc_usable), .mem_req(mem_req), .mem_addr(mem_addr),
        .coproc_req(coproc_req), .coproc_num(coproc_num), .coproc_reg(coproc_reg), .gpr_we(gpr_we),
        .gpr_waddr(gpr_waddr), .gpr_wdata(gpr_wdata), .exc_valid(exc_valid), .exc_code(exc_code),
        .product_high_register(hi), .product_low_register(lo));
    clmx_far_model far (.mclk(mclk), .mem_req(mem_req), .mem_addr(mem_addr), .coproc_req(coproc_req),
        .coproc_num(coproc_num), .coproc_reg(coproc_reg), .mem_rdata(mem_rdata), .coproc_rdata(coproc_rdata));

    // one-cycle pulses are caught at the edge where they stand
    always @(posedge mclk) begin
        if (gpr_we === 1'b1) begin
            wr_n++;
            wr_a = gpr_waddr;
            wr_d = gpr_wdata;
        end
        if (exc_valid === 1'b1) begin
            ex_n++;
            ex_c = exc_code;
        end
        if (mem_req === 1'b1 || coproc_req === 1'b1) begin
            rq_n++;
            rq_a = mem_req ? mem_addr : {25'h0, coproc_num, coproc_reg};
        end
    end

    // ==========================================
    // shared tasks
    // ==========================================
    task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic issue(input logic [31:0] i, input logic [31:0] s, input logic [31:0] t);
        instr_valid <= 1'b1;
        instr <= i;
        source_gpr_value <= s;
        target_gpr_value <= t;
        @(posedge mclk);
    endtask
    // idle long enough for the two-cycle load path to finish
    task automatic settle();
        instr_valid <= 1'b0;
        repeat (4) @(posedge mclk);
    endtask
    // zero the event counters before a new request; nothing stands when called
    task automatic restart();
        wr_n = 0;
        ex_n = 0;
        rq_n = 0;
        ex_c = 2'h0;
    endtask
    // little-endian byte merge of a memory word into an old register value
    function automatic logic [31:0] merge_exp(logic [31:0] w, logic [31:0] old, logic [1:0] k, logic left);
        if (left) return (w << (8 * (3 - k))) | (old & (32'hffff_ffff >> (8 * (k + 1))));
        return (w >> (8 * k)) | (old & ~(32'hffff_ffff >> (8 * k)));
    endfunction

    // ==========================================
    // scenarios
    // ==========================================
    task automatic t_upper();
        restart();
        issue({clmx_pkg::OP_LOAD_UPPER, 5'h00, 5'h03, 16'hbeef}, 32'h1234_5678, 32'h9abc_def0);
        settle();
        chk("upper_write", {wr_n[26:0], wr_a, wr_d}, {27'h1, 5'h03, 32'hbeef_0000});
    endtask
    task automatic t_word();
        restart();
        issue({clmx_pkg::OP_LOAD_WORD, 5'h01, 5'h04, 16'hfffc}, 32'h0000_1000, 32'h0);
        settle();
        chk("word_addr", {32'(rq_n), rq_a}, {32'h1, 32'h0000_0ffc});
        chk("word_write", {wr_n[26:0], wr_a, wr_d}, {27'h1, 5'h04, 32'h0000_0ffc ^ KEY});
        restart();
        issue({clmx_pkg::OP_LOAD_WORD, 5'h01, 5'h04, 16'h0001}, 32'h0000_1001, 32'h0);
        settle();
        chk("word_misalign", {16'(wr_n), 16'(rq_n), 16'(ex_n), 14'h0, ex_c}, {16'h0, 16'h0, 16'h1, 16'h1});
    endtask
    task automatic t_partial();
        logic [31:0] eff;
        for (int k = 0; k < 4; k++) begin
            for (int lf = 0; lf < 2; lf++) begin
                eff = 32'h2000_0010 + 32'(k);
                restart();
                issue({lf ? clmx_pkg::OP_LOAD_LEFT : clmx_pkg::OP_LOAD_RIGHT, 5'h01, 5'(10 + 2 * k + lf),
                       16'h0010}, eff - 32'h10, 32'h1122_3344);
                settle();
                chk("part_addr", {32'(rq_n), rq_a}, {32'h1, eff & 32'hffff_fffc});
                chk("part_exc", 64'(ex_n), 64'h0);
                chk("part_data", {32'(wr_n), wr_d}, {32'h1,
                    merge_exp(32'h2000_0010 ^ KEY, 32'h1122_3344, 2'(k), 1'(lf))});
            end
        end
    endtask
    task automatic t_forward();
        restart();
        issue({clmx_pkg::OP_LOAD_WORD, 5'h01, 5'h05, 16'h0020}, 32'h3000_0000, 32'h0);
        issue({clmx_pkg::OP_LOAD_RIGHT, 5'h01, 5'h05, 16'h0041}, 32'h3000_0000, 32'h0bad_0bad);
        settle();
        chk("fwd_data", {32'(wr_n), wr_d}, {32'h2,
            merge_exp(32'h3000_0040 ^ KEY, 32'h3000_0020 ^ KEY, 2'h1, 1'b0)});
    endtask
    task automatic t_macc();
        logic [63:0] acc;
        logic [31:0] a;
        logic [31:0] b;
        acc = 64'h0;
        // two accumulates in turn with idle cycles between, no divide placed after them
        for (int n = 0; n < 2; n++) begin
            a = n ? 32'hffff_ffff : 32'hffff_fffd;
            b = n ? 32'h0000_0002 : 32'h0000_0007;
            acc = acc + (n ? {32'h0, a} * {32'h0, b} : {{32{a[31]}}, a} * {{32{b[31]}}, b});
            restart();
            issue({clmx_pkg::OP_MUL_ACC, 5'h01, 5'h02, 5'h09, 5'h00,
                   n ? clmx_pkg::FN_MACC_UNSIGN : clmx_pkg::FN_MACC_SIGNED}, a, b);
            settle();
            chk("macc_pair", {hi, lo}, acc);
            chk("macc_write", {wr_n[26:0], wr_a, wr_d}, {27'h1, 5'h09, acc[31:0]});
            chk("macc_exc", 64'(ex_n), 64'h0);
        end
    endtask
    task automatic t_move();
        logic u;
        for (int m = 0; m < 2; m++) begin
            coproc_usable <= m ? 4'ha : 4'h5;
            for (int z = 0; z < 4; z++) begin
                u = (z % 2) == m;
                restart();
                issue({clmx_pkg::OP_COPROC_HIGH, 2'(z), clmx_pkg::SUB_MOVE_FROM, 5'h07, 5'h0c, 11'h0}, 0, 0);
                settle();
                chk("move_cnt", {16'(wr_n), 16'(ex_n), 16'(rq_n), 14'h0, ex_c},
                    u ? {16'h1, 16'h0, 16'h1, 16'h0} : {16'h0, 16'h1, 16'h0, 16'h2});
                if (u) chk("move_data", {wr_a, wr_d}, {5'h07, 6'h2a, 2'(z), 19'h0, 5'h0c});
            end
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // main sequence after a ten-cycle reset
    initial begin
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        settle();
        t_upper();
        t_word();
        t_partial();
        t_forward();
        t_macc();
        t_move();
        print_verdict();
    end
    // watchdog well past the roughly 130 cycles the tests need
    initial begin
        repeat (2000) @(posedge mclk);
        n_errors++;
        print_verdict();
    end
endmodule

//--- bench/clmx_far_model.sv
// ==========================================
// far side: data memory and coprocessor files
// ==========================================
module clmx_far_model (
    input  wire logic        mclk,
    input  wire logic        mem_req,
    input  wire logic [31:0] mem_addr,
    input  wire logic        coproc_req,
    input  wire logic [1:0]  coproc_num,
    input  wire logic [4:0]  coproc_reg,
    output logic      [31:0] mem_rdata,
    output logic      [31:0] coproc_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] junk_q = 32'h0000_0000;
    // idle pattern moves every cycle, so stale data never passes for a read
    always @(posedge mclk) begin
        junk_q <= junk_q + 32'h0101_0101;
    end
    // contents follow the address and the unit, so a wrong select shows
    assign mem_rdata    = mem_req ? (mem_addr ^ 32'h5a0f_c3e1) : ~junk_q;
    assign coproc_rdata = coproc_req ? {6'h2a, coproc_num, 19'h0, coproc_reg} : junk_q;
endmodule

//--- inc/clmx_pkg.sv
// ==========================================
// overview and shared constants
// ==========================================
package clmx_pkg;
    localparam logic [5:0] OP_LOAD_UPPER   = 6'h0f;
    localparam logic [5:0] OP_LOAD_WORD    = 6'h23;
    localparam logic [5:0] OP_LOAD_LEFT    = 6'h22;
    localparam logic [5:0] OP_LOAD_RIGHT   = 6'h26;
    localparam logic [5:0] OP_MUL_ACC      = 6'h1c;
    localparam logic [5:0] FN_MACC_SIGNED  = 6'h00;
    localparam logic [5:0] FN_MACC_UNSIGN  = 6'h01;
    localparam logic [3:0] OP_COPROC_HIGH  = 4'h4;
    localparam logic [4:0] SUB_MOVE_FROM   = 5'h00;
    localparam logic [1:0] ALIGNED_LOW     = 2'h0;
    localparam int         OPC_MSB = 31;
    localparam int         OPC_LSB = 26;
    localparam int         RS_MSB  = 25;
    localparam int         RS_LSB  = 21;
    localparam int         RT_MSB  = 20;
    localparam int         RT_LSB  = 16;
    localparam int         RD_MSB  = 15;
    localparam int         RD_LSB  = 11;
    localparam int         IMM_MSB = 15;
    localparam logic [15:0] HALF_ZERO = 16'h0000;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
    localparam logic [63:0] PAIR_ZERO = 64'h0;
    localparam logic [1:0]  EXC_NONE    = 2'h0;
    localparam logic [1:0]  EXC_ADDRESS = 2'h1;
    localparam logic [1:0]  EXC_COPROC  = 2'h2;
    typedef enum logic [2:0] {CLMX_NONE, CLMX_UPPER, CLMX_WORD, CLMX_LEFT, CLMX_RIGHT,
                              CLMX_MACC, CLMX_MOVE} clmx_kind_e;
endpackage

//--- src/clmx_exec.sv
// ==========================================
// decode and execute for loads, multiply-accumulate, coprocessor moves
// ==========================================
module clmx_exec (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        instr_valid,
    input  wire logic [31:0] instr,
    input  wire logic [31:0] source_gpr_value,
    input  wire logic [31:0] target_gpr_value,
    input  wire logic [31:0] mem_rdata,
    input  wire logic [31:0] coproc_rdata,
    input  wire logic [3:0]  coproc_usable,
    output logic             mem_req,
    output logic      [31:0] mem_addr,
    output logic             coproc_req,
    output logic      [1:0]  coproc_num,
    output logic      [4:0]  coproc_reg,
    output logic             gpr_we,
    output logic      [4:0]  gpr_waddr,
    output logic      [31:0] gpr_wdata,
    output logic             exc_valid,
    output logic      [1:0]  exc_code,
    output logic      [31:0] product_high_register,
    output logic      [31:0] product_low_register
);
    // ==========================================
    // field extraction and decode
    // ==========================================
    wire [5:0]  opc   = instr[clmx_pkg::OPC_MSB:clmx_pkg::OPC_LSB];
    wire [4:0]  rs_f  = instr[clmx_pkg::RS_MSB:clmx_pkg::RS_LSB];
    wire [4:0]  target_gpr_field = instr[clmx_pkg::RT_MSB:clmx_pkg::RT_LSB];
    wire [4:0]  rd_f  = instr[clmx_pkg::RD_MSB:clmx_pkg::RD_LSB];
    wire [5:0]  fn_f  = instr[5:0];
    wire [15:0] imm   = instr[clmx_pkg::IMM_MSB:0];

    wire is_upper = opc == clmx_pkg::OP_LOAD_UPPER;
    wire is_word  = opc == clmx_pkg::OP_LOAD_WORD;
    wire is_left  = opc == clmx_pkg::OP_LOAD_LEFT;
    wire is_right = opc == clmx_pkg::OP_LOAD_RIGHT;
    wire is_macs  = opc == clmx_pkg::OP_MUL_ACC && fn_f == clmx_pkg::FN_MACC_SIGNED;
    wire is_macu  = opc == clmx_pkg::OP_MUL_ACC && fn_f == clmx_pkg::FN_MACC_UNSIGN;
    // coprocessor number sits in the two low opcode bits; unit 0 is system control
    wire is_move  = opc[5:2] == clmx_pkg::OP_COPROC_HIGH && rs_f == clmx_pkg::SUB_MOVE_FROM;

    clmx_pkg::clmx_kind_e kind;
    assign kind = !instr_valid ? clmx_pkg::CLMX_NONE :
                  is_upper ? clmx_pkg::CLMX_UPPER :
                  is_word  ? clmx_pkg::CLMX_WORD  :
                  is_left  ? clmx_pkg::CLMX_LEFT  :
                  is_right ? clmx_pkg::CLMX_RIGHT :
                  (is_macs || is_macu) ? clmx_pkg::CLMX_MACC :
                  is_move  ? clmx_pkg::CLMX_MOVE  : clmx_pkg::CLMX_NONE;

    // ==========================================
    // address generation and load issue
    // ==========================================
    wire [31:0] eff_addr = source_gpr_value + {{16{imm[15]}}, imm};
    // only the word load checks alignment; partial loads never trap
    wire        misalign = eff_addr[1:0] != clmx_pkg::ALIGNED_LOW;
    wire        is_load  = kind == clmx_pkg::CLMX_WORD || kind == clmx_pkg::CLMX_LEFT ||
                           kind == clmx_pkg::CLMX_RIGHT;
    wire        load_ok  = is_load && !(kind == clmx_pkg::CLMX_WORD && misalign);
    wire [1:0]  cp_n     = opc[1:0];
    wire        move_ok  = kind == clmx_pkg::CLMX_MOVE && coproc_usable[cp_n];

    // load and move stage registers
    clmx_pkg::clmx_kind_e pend_kind_q;
    logic [4:0]  pend_reg_q;
    logic [1:0]  pend_off_q;
    logic [31:0] pend_old_q;

    // ==========================================
    // forwarding of a load result still in flight
    // ==========================================
    // the register file has not seen the pending write yet, so bypass it
    wire        pend_load = pend_kind_q == clmx_pkg::CLMX_WORD || pend_kind_q == clmx_pkg::CLMX_LEFT ||
                            pend_kind_q == clmx_pkg::CLMX_RIGHT;
    wire        fwd_hit   = pend_load && pend_reg_q == target_gpr_field;

    wire [31:0] merged;
    clmx_merge u_merge (
        .mem_word  (mem_rdata),
        .old_value (pend_old_q),
        .offset    (pend_off_q),
        .left      (pend_kind_q == clmx_pkg::CLMX_LEFT),
        .merged    (merged)
    );

    wire [31:0] load_result = pend_kind_q == clmx_pkg::CLMX_WORD ? mem_rdata : merged;
    wire [31:0] old_value   = fwd_hit ? load_result : target_gpr_value;

    // stage registers: request goes out now, completion follows next cycle
    always_ff @(posedge mclk) begin
        if (rst) begin
            mem_req     <= 1'b0;
            mem_addr    <= clmx_pkg::WORD_ZERO;
            coproc_req  <= 1'b0;
            coproc_num  <= 2'h0;
            coproc_reg  <= 5'h00;
            pend_kind_q <= clmx_pkg::CLMX_NONE;
            pend_reg_q  <= 5'h00;
            pend_off_q  <= 2'h0;
            pend_old_q  <= clmx_pkg::WORD_ZERO;
        end else begin
            mem_req     <= load_ok;
            mem_addr    <= {eff_addr[31:2], clmx_pkg::ALIGNED_LOW};
            coproc_req  <= move_ok;
            coproc_num  <= cp_n;
            coproc_reg  <= rd_f;
            pend_kind_q <= (load_ok || move_ok) ? kind : clmx_pkg::CLMX_NONE;
            pend_reg_q  <= target_gpr_field;
            pend_off_q  <= eff_addr[1:0];
            pend_old_q  <= old_value;
        end
    end

    // ==========================================
    // multiply-accumulate
    // ==========================================
    // full 64-bit wrap; no overflow detection exists at all
    wire signed [63:0] prod_s = $signed(source_gpr_value) * $signed(target_gpr_value);
    wire        [63:0] prod_u = {32'h0, source_gpr_value} * {32'h0, target_gpr_value};
    wire        [63:0] acc    = {product_high_register, product_low_register} +
                                (is_macs ? 64'(prod_s) : prod_u);
    wire               do_macc = kind == clmx_pkg::CLMX_MACC;

    always_ff @(posedge mclk) begin
        if (rst) begin
            product_high_register <= clmx_pkg::WORD_ZERO;
            product_low_register  <= clmx_pkg::WORD_ZERO;
        end else if (do_macc) begin
            product_high_register <= acc[63:32];
            product_low_register  <= acc[31:0];
        end
    end

    // ==========================================
    // register write-back and exceptions
    // ==========================================
    // loads and moves complete one cycle later; same-cycle ops would clash,
    // so a pending completion takes the write port and the same-cycle write is dropped
    wire        pend_done = pend_kind_q != clmx_pkg::CLMX_NONE;
    wire        now_wr    = kind == clmx_pkg::CLMX_UPPER || do_macc;
    wire [31:0] now_data  = kind == clmx_pkg::CLMX_UPPER ? {imm, clmx_pkg::HALF_ZERO} : acc[31:0];
    wire [4:0]  now_reg   = kind == clmx_pkg::CLMX_UPPER ? target_gpr_field : rd_f;
    wire [31:0] pend_data = pend_kind_q == clmx_pkg::CLMX_MOVE ? coproc_rdata : load_result;
    wire        err_addr  = kind == clmx_pkg::CLMX_WORD && misalign;
    wire        err_cop   = kind == clmx_pkg::CLMX_MOVE && !coproc_usable[cp_n];

    always_ff @(posedge mclk) begin
        if (rst) begin
            gpr_we    <= 1'b0;
            gpr_waddr <= 5'h00;
            gpr_wdata <= clmx_pkg::WORD_ZERO;
            exc_valid <= 1'b0;
            exc_code  <= clmx_pkg::EXC_NONE;
        end else begin
            gpr_we    <= pend_done || now_wr;
            gpr_waddr <= pend_done ? pend_reg_q : now_reg;
            gpr_wdata <= pend_done ? pend_data : now_data;
            exc_valid <= err_addr || err_cop;
            exc_code  <= err_addr ? clmx_pkg::EXC_ADDRESS :
                         err_cop ? clmx_pkg::EXC_COPROC : clmx_pkg::EXC_NONE;
        end
    end

    // ==========================================
    // checks
    // ==========================================
    property p_upper;
        @(posedge mclk) disable iff (rst)
        (kind == clmx_pkg::CLMX_UPPER && !pend_done) |=> gpr_we && gpr_wdata == {$past(imm), 16'h0000};
    endproperty
    a_upper: assert property (p_upper) else $error("upper load value wrong");

    property p_addr;
        @(posedge mclk) disable iff (rst)
        load_ok |=> mem_req && mem_addr[31:2] == 30'(($past(source_gpr_value) +
                    {{16{$past(imm[15])}}, $past(imm)}) >> 2);
    endproperty
    a_addr: assert property (p_addr) else $error("load address wrong");

    property p_word;
        @(posedge mclk) disable iff (rst)
        (pend_kind_q == clmx_pkg::CLMX_WORD) |=> gpr_we && gpr_wdata == $past(mem_rdata);
    endproperty
    a_word: assert property (p_word) else $error("word load data wrong");

    property p_misalign;
        @(posedge mclk) disable iff (rst)
        (kind == clmx_pkg::CLMX_WORD && misalign) |=> exc_valid && exc_code == clmx_pkg::EXC_ADDRESS && !mem_req;
    endproperty
    a_misalign: assert property (p_misalign) else $error("misaligned word load not trapped");

    property p_left_keep;
        @(posedge mclk) disable iff (rst)
        (pend_kind_q == clmx_pkg::CLMX_LEFT && pend_off_q != 2'h3) |=>
            gpr_wdata[7:0] == $past(pend_old_q[7:0]);
    endproperty
    a_left_keep: assert property (p_left_keep) else $error("left load clobbered low byte");

    property p_right_low;
        @(posedge mclk) disable iff (rst)
        (pend_kind_q == clmx_pkg::CLMX_RIGHT && pend_off_q == 2'h0) |=> gpr_wdata == $past(mem_rdata);
    endproperty
    a_right_low: assert property (p_right_low) else $error("right load aligned case wrong");

    property p_no_align_trap;
        @(posedge mclk) disable iff (rst)
        (kind == clmx_pkg::CLMX_LEFT || kind == clmx_pkg::CLMX_RIGHT) |=> !exc_valid && mem_req;
    endproperty
    a_no_align_trap: assert property (p_no_align_trap) else $error("partial load trapped");

    property p_macc;
        @(posedge mclk) disable iff (rst)
        (do_macc && !pend_done) |=> gpr_we && gpr_waddr == $past(rd_f) && gpr_wdata == product_low_register;
    endproperty
    a_macc: assert property (p_macc) else $error("accumulate result wrong");

    property p_unusable;
        @(posedge mclk) disable iff (rst)
        err_cop |=> exc_valid && exc_code == clmx_pkg::EXC_COPROC && !coproc_req;
    endproperty
    a_unusable: assert property (p_unusable) else $error("unusable coprocessor not trapped");

    // a refused move leaves nothing pending, so no register is written
    property p_unusable_nowrite;
        @(posedge mclk) disable iff (rst)
        err_cop |=> pend_kind_q == clmx_pkg::CLMX_NONE;
    endproperty
    a_unusable_nowrite: assert property (p_unusable_nowrite) else $error("refused move still pending");

    // a trapped word load leaves nothing pending either
    property p_misalign_nowrite;
        @(posedge mclk) disable iff (rst)
        (kind == clmx_pkg::CLMX_WORD && misalign) |=> pend_kind_q == clmx_pkg::CLMX_NONE;
    endproperty
    a_misalign_nowrite: assert property (p_misalign_nowrite) else $error("trapped load still pending");

    // a move names its unit and register one cycle after issue
    property p_move_req;
        @(posedge mclk) disable iff (rst)
        move_ok |=> coproc_req && coproc_num == $past(opc[1:0]) && coproc_reg == $past(rd_f);
    endproperty
    a_move_req: assert property (p_move_req) else $error("coprocessor select wrong");

    // the unit's answer lands in the target register
    property p_move_write;
        @(posedge mclk) disable iff (rst)
        (pend_kind_q == clmx_pkg::CLMX_MOVE) |=> gpr_we && gpr_waddr == $past(pend_reg_q) &&
            gpr_wdata == $past(coproc_rdata);
    endproperty
    a_move_write: assert property (p_move_write) else $error("coprocessor move data wrong");

    // word load then partial load to one register: merge base is the loaded word
    property p_forward;
        @(posedge mclk) disable iff (rst)
        (pend_kind_q == clmx_pkg::CLMX_WORD && pend_reg_q == target_gpr_field &&
            (kind == clmx_pkg::CLMX_LEFT || kind == clmx_pkg::CLMX_RIGHT)) |=> pend_old_q == $past(mem_rdata);
    endproperty
    a_forward: assert property (p_forward) else $error("load result not forwarded");

    // left load puts the addressed byte at the top of the register
    property p_left_top;
        @(posedge mclk) disable iff (rst)
        (pend_kind_q == clmx_pkg::CLMX_LEFT) |=>
            gpr_wdata[31:24] == 8'($past(mem_rdata >> {pend_off_q, 3'b000}));
    endproperty
    a_left_top: assert property (p_left_top) else $error("left load top byte wrong");

    // right load puts the addressed byte at the bottom of the register
    property p_right_bottom;
        @(posedge mclk) disable iff (rst)
        (pend_kind_q == clmx_pkg::CLMX_RIGHT) |=>
            gpr_wdata[7:0] == 8'($past(mem_rdata >> {pend_off_q, 3'b000}));
    endproperty
    a_right_bottom: assert property (p_right_bottom) else $error("right load bottom byte wrong");

    // every read names one aligned word
    property p_word_aligned;
        @(posedge mclk) disable iff (rst)
        mem_req |-> mem_addr[1:0] == clmx_pkg::ALIGNED_LOW;
    endproperty
    a_word_aligned: assert property (p_word_aligned) else $error("read address not aligned");

    // signed accumulate: both factors sign-extended to the pair width
    property p_macc_signed;
        @(posedge mclk) disable iff (rst)
        (do_macc && is_macs) |=> {product_high_register, product_low_register} ==
            $past({product_high_register, product_low_register}) +
            $past({{32{source_gpr_value[31]}}, source_gpr_value} * {{32{target_gpr_value[31]}}, target_gpr_value});
    endproperty
    a_macc_signed: assert property (p_macc_signed) else $error("signed accumulate wrong");

    // unsigned accumulate: both factors zero-extended
    property p_macc_unsigned;
        @(posedge mclk) disable iff (rst)
        (do_macc && is_macu) |=> {product_high_register, product_low_register} ==
            $past({product_high_register, product_low_register}) +
            $past({clmx_pkg::WORD_ZERO, source_gpr_value} * {clmx_pkg::WORD_ZERO, target_gpr_value});
    endproperty
    a_macc_unsigned: assert property (p_macc_unsigned) else $error("unsigned accumulate wrong");

    // accumulate wraps silently, whatever the sum
    property p_macc_noexc;
        @(posedge mclk) disable iff (rst)
        do_macc |=> !exc_valid;
    endproperty
    a_macc_noexc: assert property (p_macc_noexc) else $error("accumulate raised exception");
endmodule

//--- src/clmx_merge.sv
// ==========================================
// partial-word merge
// ==========================================
module clmx_merge (
    input  wire logic [31:0] mem_word,
    input  wire logic [31:0] old_value,
    input  wire logic [1:0]  offset,
    input  wire logic        left,
    output logic      [31:0] merged
);
    // byte lane i of result: memory byte or old register byte
    genvar i;
    generate
        for (i = 0; i < 4; i++) begin : g_lane
            // left: lane i gets memory byte i-(3-off) when i >= 3-off
            wire       take_l = (i >= 3 - int'(offset));
            // right: lane i gets memory byte i+off when i+off <= 3
            wire       take_r = (i + int'(offset) <= 3);
            wire [1:0] src_l  = 2'(i - 3 + int'(offset));
            wire [1:0] src_r  = 2'(i + int'(offset));
            wire [1:0] src    = left ? src_l : src_r;
            wire       take   = left ? take_l : take_r;
            // uncovered lanes keep old contents
            assign merged[8*i +: 8] = take ? mem_word[8*src +: 8] : old_value[8*i +: 8];
        end
    endgenerate
endmodule
